// ===== rtl/lin_mode_pkg.sv
// Package with modes, timing constants and reset values for the LIN mode control
package lin_mode_pkg;
  // Operating modes, one-hot
  typedef enum logic [3:0] {
    MODE_STANDBY = 4'h1,
    MODE_NORMAL = 4'h2,
    MODE_LOWSLOPE = 4'h4,
    MODE_SLEEP = 4'h8
  } mode_t;

  localparam int CLK_MHZ = 125;
  // Timing figures in their own units
  localparam int UV_FILTER_NS = 5000;
  localparam int RST_EXT_US = 6000;
  localparam int WAKE_DEB_MIN_US = 8;
  localparam int WAKE_DEB_MAX_US = 54;
  localparam int BUS_HOLD_US = 150;
  // Cycle counts derived from the clock rate
  localparam int UV_FILTER_CYC = (UV_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_EXT_CYC = RST_EXT_US * CLK_MHZ;
  localparam int WAKE_DEB_CYC = ((WAKE_DEB_MIN_US + WAKE_DEB_MAX_US) / 2) * CLK_MHZ;
  localparam int BUS_HOLD_CYC = BUS_HOLD_US * CLK_MHZ;
  localparam int CNT_W = 20;
  // Buffer geometry
  localparam int BUF_DEPTH = 2;
  localparam int BUF_WIDTH = 1;
  // Values after reset
  localparam logic RXD_RESET = 1'b1;
  localparam logic SUP_RST_RESET = 1'b0;
endpackage

// ===== rtl/rx_skid_buffer.sv
// Buffer of two queued entries plus a registered output slot, with valid and ready on both sides
module rx_skid_buffer #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int CNTW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [$clog2(DEPTH+1)-1:0] count;
    logic [WIDTH-1:0] dout;
    logic dvalid;
  } buf_state_t;

  buf_state_t state_reg;
  buf_state_t state_next;
  logic push;
  logic pop;

  // Head of queue presented from a register
  always_comb
  begin
    state_next = state_reg;
    push = in_valid && (state_reg.count < DEPTH[$clog2(DEPTH+1)-1:0]);
    pop = state_reg.count != '0 && (!state_reg.dvalid || out_ready);
    if (state_reg.dvalid && out_ready)
    begin
      state_next.dvalid = 1'b0;
    end
    if (pop)
    begin
      state_next.dout = state_reg.mem[0];
      state_next.dvalid = 1'b1;
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        state_next.mem[i] = state_reg.mem[i+1];
      end
    end
    if (push)
    begin
      state_next.mem[state_reg.count - CNTW'(pop)] = in_data;
    end
    state_next.count = state_reg.count + CNTW'(push) - CNTW'(pop);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign in_ready = state_reg.count < DEPTH[$clog2(DEPTH+1)-1:0];
  assign out_valid = state_reg.dvalid;
  assign out_data = state_reg.dout;
endmodule

// ===== rtl/lin_mode_control.sv
// Mode control, wake detection and supervisor reset of a LIN transceiver
// Notes on behaviour
// (RULE1) Power-up enters standby, regulator on, transmitter off
// (RULE2) Enable rise with transmit High: normal slope
// (RULE3) Enable rise with transmit Low: low slope
// (RULE4) Low slope transmitter waits for transmit High
// (RULE5) Aux switch High if standby input High
// (RULE6) Normal, enable Low, standby High: standby
// (RULE7) Normal, both Low: sleep, regulator off
// (RULE8) Sleep leaves to standby on any wake
// (RULE9) Local wake on either edge, sleep only
// (RULE10) Local wake edges debounced 8 to 54 us
// (RULE11) Bus wake: falling, long dominant, rising
// (RULE12) Standby receive Low after bus wake only
// (RULE13) Normal modes receive follows bus level
// (RULE14) Standby: receiver on, termination off, pull-up
// (RULE15) Thermal shutdown disables transmitter and regulator
// (RULE16) Filtered undervoltage pulls reset Low
// (RULE17) Undervoltage forces standby with reset
// (RULE18) Reset release extended 6 ms
// (RULE19) Sleep holds reset Low throughout
// (RULE20) Control inputs ignored while reset Low
// (RULE21) Normal: reset High, termination connected
// (RULE22) Intervals timed by counters on clock
module lin_mode_control #(
  parameter int UV_FILTER_CYCLES = lin_mode_pkg::UV_FILTER_CYC,
  parameter int RST_EXT_CYCLES = lin_mode_pkg::RST_EXT_CYC,
  parameter int WAKE_DEB_CYCLES = lin_mode_pkg::WAKE_DEB_CYC,
  parameter int BUS_HOLD_CYCLES = lin_mode_pkg::BUS_HOLD_CYC
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic MODE_LATCH_IN,
  input wire logic STANDBY_CTL_IN,
  input wire logic TRANSMIT_LINE_IN,
  input wire logic LOCAL_ROUSE_IN,
  input wire logic BUS_LEVEL_IN,
  input wire logic UNDERVOLT_IN,
  input wire logic THERMAL_SHUTDOWN_IN,
  input wire logic RX_READY_IN,
  output logic RECEIVE_DATA_OUT,
  output logic RX_VALID_OUT,
  output logic SUPPLY_RESET_OUT,
  output logic AUX_SUPPLY_SWITCH_OUT,
  output logic AUX_SUPPLY_SWITCH_OE,
  output logic BUS_DRIVE_LOW_OUT,
  output logic TX_ENABLE_OUT,
  output logic LOW_SLOPE_OUT,
  output logic TERMINATION_ON_OUT,
  output logic REGULATOR_ON_OUT,
  output logic [3:0] MODE_OUT
);
  localparam int CW = lin_mode_pkg::CNT_W;

  typedef struct packed {
    lin_mode_pkg::mode_t mode;
    logic latch_prev;
    logic tx_armed;
    logic aux_on;
    logic rouse_prev;
    logic rouse_pend;
    logic [CW-1:0] rouse_cnt;
    logic bus_prev;
    logic bus_dom_seen;
    logic bus_long;
    logic [CW-1:0] bus_cnt;
    logic bus_woke;
    logic [CW-1:0] uv_cnt;
    logic uv_flag;
    logic [CW-1:0] ext_cnt;
    logic rst_released;
    logic rx_level;
    logic rx_valid;
    logic tx_en;
    logic drive_low;
    logic term_on;
    logic reg_on;
  } ctl_state_t;

  ctl_state_t state_reg;
  ctl_state_t state_next;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [0:0] buf_out_data;
  logic buf_out_ready;
  logic latch_rise;
  logic local_wake;
  logic bus_wake;

  // Received bus level goes through the buffer toward the controller
  rx_skid_buffer #(
    .WIDTH(lin_mode_pkg::BUF_WIDTH),
    .DEPTH(lin_mode_pkg::BUF_DEPTH)
  ) u_rx_buf (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .in_valid(state_reg.rx_valid),
    .in_ready(buf_in_ready),
    .in_data(state_reg.rx_level),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );
  // Head moves on when the sink takes or the output slot is empty
  assign buf_out_ready = RX_READY_IN || !RX_VALID_OUT;

  always_comb
  begin
    state_next = state_reg;
    latch_rise = MODE_LATCH_IN && !state_reg.latch_prev;
    local_wake = 1'b0;
    bus_wake = 1'b0;
    state_next.latch_prev = MODE_LATCH_IN;
    state_next.rouse_prev = LOCAL_ROUSE_IN;
    state_next.bus_prev = BUS_LEVEL_IN;

    // (RULE9) Edge arms filter in sleep only
    // (RULE10) Level must hold through debounce
    // (RULE22) Debounce counter
    if (state_reg.mode == lin_mode_pkg::MODE_SLEEP)
    begin
      if (LOCAL_ROUSE_IN != state_reg.rouse_prev)
      begin
        state_next.rouse_pend = 1'b1;
        state_next.rouse_cnt = '0;
      end
      else if (state_reg.rouse_pend)
      begin
        if (state_reg.rouse_cnt >= CW'(WAKE_DEB_CYCLES - 1))
        begin
          local_wake = 1'b1;
          state_next.rouse_pend = 1'b0;
        end
        else
        begin
          state_next.rouse_cnt = state_reg.rouse_cnt + 1'b1;
        end
      end
    end
    else
    begin
      state_next.rouse_pend = 1'b0;
      state_next.rouse_cnt = '0;
    end

    // (RULE11) Falling edge, long dominant, then rising edge
    if (state_reg.mode == lin_mode_pkg::MODE_SLEEP ||
        state_reg.mode == lin_mode_pkg::MODE_STANDBY)
    begin
      if (!BUS_LEVEL_IN && state_reg.bus_prev)
      begin
        state_next.bus_dom_seen = 1'b1;
        state_next.bus_long = 1'b0;
        state_next.bus_cnt = '0;
      end
      else if (!BUS_LEVEL_IN && state_reg.bus_dom_seen)
      begin
        if (state_reg.bus_cnt >= CW'(BUS_HOLD_CYCLES))
        begin
          state_next.bus_long = 1'b1;
        end
        else
        begin
          state_next.bus_cnt = state_reg.bus_cnt + 1'b1;
        end
      end
      else if (BUS_LEVEL_IN && !state_reg.bus_prev)
      begin
        bus_wake = state_reg.bus_dom_seen && state_reg.bus_long;
        state_next.bus_dom_seen = 1'b0;
        state_next.bus_long = 1'b0;
      end
    end
    else
    begin
      state_next.bus_dom_seen = 1'b0;
      state_next.bus_long = 1'b0;
      state_next.bus_cnt = '0;
    end

    // (RULE16) Undervoltage filter outside sleep
    if (state_reg.mode != lin_mode_pkg::MODE_SLEEP && UNDERVOLT_IN)
    begin
      if (state_reg.uv_cnt >= CW'(UV_FILTER_CYCLES))
      begin
        state_next.uv_flag = 1'b1;
      end
      else
      begin
        state_next.uv_cnt = state_reg.uv_cnt + 1'b1;
      end
    end
    else
    begin
      state_next.uv_cnt = '0;
      state_next.uv_flag = 1'b0;
    end

    // Mode transitions
    case (state_reg.mode)
      lin_mode_pkg::MODE_STANDBY:
      begin
        // (RULE20) Inputs only act with reset released
        if (state_reg.rst_released && latch_rise)
        begin
          // (RULE2) Normal slope select
          // (RULE3) Low slope select
          state_next.mode = TRANSMIT_LINE_IN ? lin_mode_pkg::MODE_NORMAL :
            lin_mode_pkg::MODE_LOWSLOPE;
          // (RULE4) Transmitter armed only when transmit High
          state_next.tx_armed = TRANSMIT_LINE_IN;
          // (RULE5) Aux switch sampled at transition
          state_next.aux_on = STANDBY_CTL_IN;
          state_next.bus_woke = 1'b0;
        end
      end
      lin_mode_pkg::MODE_NORMAL, lin_mode_pkg::MODE_LOWSLOPE:
      begin
        if (state_reg.rst_released && !MODE_LATCH_IN)
        begin
          // (RULE6) To standby
          // (RULE7) To sleep
          state_next.mode = STANDBY_CTL_IN ? lin_mode_pkg::MODE_STANDBY :
            lin_mode_pkg::MODE_SLEEP;
          state_next.aux_on = 1'b0;
        end
        else if (state_reg.rst_released && TRANSMIT_LINE_IN)
        begin
          state_next.tx_armed = 1'b1;
        end
      end
      lin_mode_pkg::MODE_SLEEP:
      begin
        // (RULE8) Wake returns to standby
        if (local_wake || bus_wake)
        begin
          state_next.mode = lin_mode_pkg::MODE_STANDBY;
        end
      end
      default:
      begin
        state_next.mode = lin_mode_pkg::MODE_STANDBY;
      end
    endcase

    // (RULE12) Bus wake source latched for standby
    if (bus_wake)
    begin
      state_next.bus_woke = 1'b1;
    end
    else if (local_wake)
    begin
      state_next.bus_woke = 1'b0;
    end

    // (RULE17) Undervoltage forces standby
    if (state_next.uv_flag && state_reg.mode != lin_mode_pkg::MODE_SLEEP)
    begin
      state_next.mode = lin_mode_pkg::MODE_STANDBY;
      state_next.aux_on = 1'b0;
      state_next.tx_armed = 1'b0;
    end

    // (RULE18) Reset extension after recovery
    // (RULE19) Sleep forces reset Low
    if (state_next.mode == lin_mode_pkg::MODE_SLEEP || state_next.uv_flag)
    begin
      state_next.rst_released = 1'b0;
      state_next.ext_cnt = '0;
    end
    else if (!state_reg.rst_released)
    begin
      if (UNDERVOLT_IN)
      begin
        state_next.ext_cnt = '0;
      end
      else if (state_reg.ext_cnt >= CW'(RST_EXT_CYCLES - 1))
      begin
        state_next.rst_released = 1'b1;
      end
      else
      begin
        state_next.ext_cnt = state_reg.ext_cnt + 1'b1;
      end
    end

    // Output stage from next mode
    // (RULE15) Thermal shutdown overrides
    // (RULE14) Standby: termination off, transmitter off
    // (RULE21) Termination on in normal modes
    state_next.reg_on = state_next.mode != lin_mode_pkg::MODE_SLEEP && !THERMAL_SHUTDOWN_IN;
    state_next.term_on = state_next.mode == lin_mode_pkg::MODE_NORMAL ||
      state_next.mode == lin_mode_pkg::MODE_LOWSLOPE;
    state_next.tx_en = state_next.term_on && state_next.tx_armed && !THERMAL_SHUTDOWN_IN;
    state_next.drive_low = state_next.tx_en && !TRANSMIT_LINE_IN;

    // (RULE13) Receive follows bus in normal modes
    // (RULE12) Standby shows wake source
    if (state_next.term_on)
    begin
      state_next.rx_level = BUS_LEVEL_IN;
    end
    else if (state_next.mode == lin_mode_pkg::MODE_STANDBY)
    begin
      state_next.rx_level = !state_next.bus_woke;
    end
    else
    begin
      state_next.rx_level = 1'b1;
    end
    // Sample offered to buffer only when it had room the cycle before
    state_next.rx_valid = buf_in_ready && state_next.term_on;
  end

  // (RULE1) Reset lands in standby, regulator on
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      state_reg <= '0;
      state_reg.mode <= lin_mode_pkg::MODE_STANDBY;
      state_reg.latch_prev <= 1'b1;
      state_reg.rouse_prev <= 1'b0;
      state_reg.bus_prev <= 1'b1;
      state_reg.rst_released <= lin_mode_pkg::SUP_RST_RESET;
      state_reg.rx_level <= lin_mode_pkg::RXD_RESET;
      state_reg.reg_on <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Registered outputs
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      RECEIVE_DATA_OUT <= lin_mode_pkg::RXD_RESET;
      RX_VALID_OUT <= 1'b0;
      SUPPLY_RESET_OUT <= lin_mode_pkg::SUP_RST_RESET;
      AUX_SUPPLY_SWITCH_OUT <= 1'b0;
      AUX_SUPPLY_SWITCH_OE <= 1'b0;
      BUS_DRIVE_LOW_OUT <= 1'b0;
      TX_ENABLE_OUT <= 1'b0;
      LOW_SLOPE_OUT <= 1'b0;
      TERMINATION_ON_OUT <= 1'b0;
      REGULATOR_ON_OUT <= 1'b1;
      MODE_OUT <= lin_mode_pkg::MODE_STANDBY;
    end
    else
    begin
      RECEIVE_DATA_OUT <= state_reg.term_on ? ((buf_out_valid && buf_out_ready) ?
        buf_out_data[0] : RECEIVE_DATA_OUT) : state_reg.rx_level;
      RX_VALID_OUT <= (buf_out_valid && buf_out_ready) || (RX_VALID_OUT && !RX_READY_IN);
      SUPPLY_RESET_OUT <= state_reg.rst_released;
      AUX_SUPPLY_SWITCH_OUT <= state_reg.aux_on;
      AUX_SUPPLY_SWITCH_OE <= state_reg.aux_on;
      BUS_DRIVE_LOW_OUT <= state_reg.drive_low;
      TX_ENABLE_OUT <= state_reg.tx_en;
      LOW_SLOPE_OUT <= state_reg.mode == lin_mode_pkg::MODE_LOWSLOPE;
      TERMINATION_ON_OUT <= state_reg.term_on;
      REGULATOR_ON_OUT <= state_reg.reg_on;
      MODE_OUT <= state_reg.mode;
    end
  end
endmodule

// ===== testbench/lin_mode_props_properties.sv
// Checker for mode, reset and output policy of the LIN mode control
module lin_mode_props #(
  parameter int UV_FILTER_CYCLES = 4,
  parameter int RST_EXT_CYCLES = 20
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic UNDERVOLT_IN,
  input wire logic THERMAL_SHUTDOWN_IN,
  input wire logic SUPPLY_RESET_OUT,
  input wire logic AUX_SUPPLY_SWITCH_OE,
  input wire logic TX_ENABLE_OUT,
  input wire logic TERMINATION_ON_OUT,
  input wire logic REGULATOR_ON_OUT,
  input wire logic [3:0] MODE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  int uv_run_reg;
  int ok_run_reg;
  // Runs of undervoltage and of good supply outside sleep
  always_ff @(posedge CLK_SYS)
  begin
    uv_run_reg <= (SYS_RST || !UNDERVOLT_IN) ? 0 : uv_run_reg + 1;
    ok_run_reg <= (SYS_RST || UNDERVOLT_IN || MODE_OUT == 4'h8) ? 0 : ok_run_reg + 1;
  end
  property p_sleep_rst;
    MODE_OUT == 4'h8 |-> !SUPPLY_RESET_OUT;
  endproperty
  a_sleep_rst: assert property (p_sleep_rst) else $error("reset high in sleep");
  property p_sleep_reg;
    MODE_OUT == 4'h8 |-> !REGULATOR_ON_OUT;
  endproperty
  a_sleep_reg: assert property (p_sleep_reg) else $error("regulator on in sleep");
  property p_norm_term;
    MODE_OUT inside {4'h2, 4'h4} |-> TERMINATION_ON_OUT && SUPPLY_RESET_OUT;
  endproperty
  a_norm_term: assert property (p_norm_term) else $error("normal without termination");
  property p_stby_off;
    MODE_OUT == 4'h1 |-> !TERMINATION_ON_OUT && !TX_ENABLE_OUT;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("standby drives bus");
  property p_aux_float;
    MODE_OUT inside {4'h1, 4'h8} |-> !AUX_SUPPLY_SWITCH_OE;
  endproperty
  a_aux_float: assert property (p_aux_float) else $error("aux switch driven");
  property p_thermal;
    THERMAL_SHUTDOWN_IN [*3] |-> !TX_ENABLE_OUT && !REGULATOR_ON_OUT;
  endproperty
  a_thermal: assert property (p_thermal) else $error("hot but still driving");
  property p_ignore;
    (MODE_OUT == 4'h1 && !SUPPLY_RESET_OUT) [*2] |=> MODE_OUT == 4'h1;
  endproperty
  a_ignore: assert property (p_ignore) else $error("mode moved in reset");
  property p_uv;
    uv_run_reg == UV_FILTER_CYCLES + 1 && MODE_OUT != 4'h8
      |-> ##[0:4] (!SUPPLY_RESET_OUT && MODE_OUT == 4'h1);
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage missed");
  property p_rst_min;
    $rose(SUPPLY_RESET_OUT) |-> ok_run_reg >= RST_EXT_CYCLES - 2;
  endproperty
  a_rst_min: assert property (p_rst_min) else $error("reset released early");
  property p_rst_max;
    ok_run_reg == RST_EXT_CYCLES + 6 && !THERMAL_SHUTDOWN_IN |-> SUPPLY_RESET_OUT;
  endproperty
  a_rst_max: assert property (p_rst_max) else $error("reset held too long");
  c_normal: cover property (MODE_OUT == 4'h2);
  c_low: cover property (MODE_OUT == 4'h4);
  c_sleep: cover property (MODE_OUT == 4'h8);
endmodule
bind lin_mode_control lin_mode_props #(
  .UV_FILTER_CYCLES(UV_FILTER_CYCLES),
  .RST_EXT_CYCLES(RST_EXT_CYCLES)
) u_props (.CLK_SYS, .SYS_RST, .UNDERVOLT_IN, .THERMAL_SHUTDOWN_IN, .SUPPLY_RESET_OUT,
  .AUX_SUPPLY_SWITCH_OE, .TX_ENABLE_OUT, .TERMINATION_ON_OUT, .REGULATOR_ON_OUT, .MODE_OUT);

// ===== testbench/rx_sink_model.sv
// Receive sink standing in for the protocol controller
module rx_sink_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic valid,
  input wire logic data,
  output logic ready,
  output logic last_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ready drops while a stall is asked for
  assign ready = !stall;
  // Keeps the last accepted bit
  always_ff @(posedge clk)
  begin
    if (valid && ready)
    begin
      last_bit <= data;
    end
  end
endmodule

// ===== testbench/lin_transceiver_mode_control_tb.sv
// Self-checking bench for the LIN mode control
module lin_transceiver_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EXT = 20;
  logic clk = 1'b0, rst = 1'b1, latch = 1'b0, stby = 1'b0, tx = 1'b1, rouse = 1'b0;
  logic bus = 1'b1, uv = 1'b0, hot = 1'b0, stall = 1'b0, ready, last_bit;
  logic rxd, rxv, sup_rst, aux, aux_oe, drv_low, tx_en, low_sl, term, reg_on;
  logic [3:0] mode;
  int num_errors = 0, checks_done = 0, cycles = 0;
  // Clock at 125 MHz
  always #4 clk = ~clk;
  lin_mode_control #(.UV_FILTER_CYCLES(4), .RST_EXT_CYCLES(EXT), .WAKE_DEB_CYCLES(5),
    .BUS_HOLD_CYCLES(6)) DUT (.CLK_SYS(clk), .SYS_RST(rst), .MODE_LATCH_IN(latch),
    .STANDBY_CTL_IN(stby), .TRANSMIT_LINE_IN(tx), .LOCAL_ROUSE_IN(rouse), .BUS_LEVEL_IN(bus),
    .UNDERVOLT_IN(uv), .THERMAL_SHUTDOWN_IN(hot), .RX_READY_IN(ready),
    .RECEIVE_DATA_OUT(rxd), .RX_VALID_OUT(rxv), .SUPPLY_RESET_OUT(sup_rst),
    .AUX_SUPPLY_SWITCH_OUT(aux), .AUX_SUPPLY_SWITCH_OE(aux_oe), .BUS_DRIVE_LOW_OUT(drv_low),
    .TX_ENABLE_OUT(tx_en), .LOW_SLOPE_OUT(low_sl), .TERMINATION_ON_OUT(term),
    .REGULATOR_ON_OUT(reg_on), .MODE_OUT(mode));
  rx_sink_model sink (.clk(clk), .stall(stall), .valid(rxv), .data(rxd), .ready(ready),
    .last_bit(last_bit));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for the reset output to rise, returning the cycles spent
  task automatic wait_rst(output int n);
    for (n = 0; n < 200 && sup_rst !== 1'b1; n++)
      cyc(1);
    chk(sup_rst, 1'b1);
  endtask
  task automatic go(input logic t, input logic s);
    tx = t;
    stby = s;
    latch = 1'b0;
    cyc(2);
    latch = 1'b1;
    cyc(4);
  endtask
  task automatic t_power();
    int n;
    chk(mode, 4'h1);
    chk({reg_on, tx_en, rxd, sup_rst}, 4'ha);
    wait_rst(n);
    chk(n >= EXT && n <= EXT + 4, 1'b1);
    $display("power-up test done");
  endtask
  task automatic t_normal();
    go(1'b1, 1'b1);
    chk(mode, 4'h2);
    chk({aux_oe, aux, term, tx_en, low_sl}, 5'h1e);
    bus = 1'b0;
    stall = 1'b1;
    cyc(3);
    stall = 1'b0;
    cyc(8);
    chk({rxv, rxd, last_bit}, 3'b100);
    bus = 1'b1;
    cyc(6);
    chk(rxd, 1'b1);
    latch = 1'b0;
    cyc(4);
    chk(mode, 4'h1);
    chk({aux_oe, term}, 2'b00);
    $display("normal slope test done");
  endtask
  task automatic t_low();
    go(1'b0, 1'b0);
    chk(mode, 4'h4);
    chk({low_sl, aux_oe, tx_en}, 3'b100);
    tx = 1'b1;
    cyc(4);
    chk(tx_en, 1'b1);
    tx = 1'b0;
    cyc(3);
    chk({tx_en, drv_low}, 2'b11);
    stby = 1'b1;
    latch = 1'b0;
    cyc(4);
    chk(mode, 4'h1);
    $display("low slope test done");
  endtask
  task automatic to_sleep();
    go(1'b1, 1'b1);
    latch = 1'b0;
    stby = 1'b0;
    cyc(4);
    chk(mode, 4'h8);
    chk({reg_on, sup_rst}, 2'b00);
  endtask
  task automatic t_local();
    int n;
    to_sleep();
    latch = 1'b1;
    cyc(4);
    chk(mode, 4'h8);
    rouse = ~rouse;
    cyc(3);
    chk(mode, 4'h8);
    cyc(10);
    chk(mode, 4'h1);
    chk(rxd, 1'b1);
    wait_rst(n);
    $display("local wake test done");
  endtask
  task automatic t_bus();
    int n;
    to_sleep();
    bus = 1'b0;
    cyc(3);
    bus = 1'b1;
    cyc(6);
    chk(mode, 4'h8);
    bus = 1'b0;
    cyc(10);
    bus = 1'b1;
    cyc(6);
    chk(mode, 4'h1);
    chk(rxd, 1'b0);
    wait_rst(n);
    go(1'b1, 1'b1);
    cyc(2);
    chk(rxd, 1'b1);
    $display("bus wake test done");
  endtask
  task automatic t_uv();
    int n;
    uv = 1'b1;
    cyc(3);
    uv = 1'b0;
    cyc(4);
    chk({mode, sup_rst}, 5'h05);
    uv = 1'b1;
    cyc(10);
    chk({mode, sup_rst}, 5'h02);
    uv = 1'b0;
    cyc(10);
    chk(sup_rst, 1'b0);
    wait_rst(n);
    $display("undervoltage test done");
  endtask
  task automatic t_hot();
    go(1'b1, 1'b1);
    hot = 1'b1;
    cyc(4);
    chk({tx_en, reg_on}, 2'b00);
    hot = 1'b0;
    cyc(4);
    chk(tx_en, 1'b1);
    $display("thermal test done");
  endtask
  // Main sequence
  initial
  begin
    cyc(16);
    rst = 1'b0;
    cyc(1);
    t_power();
    t_normal();
    t_low();
    t_local();
    t_bus();
    t_uv();
    t_hot();
    give_verdict();
  end
endmodule
